// [logic/pwr_cfg_params.svh]
`ifndef PWR_CFG_PARAMS_SVH
`define PWR_CFG_PARAMS_SVH

// command codes of the configuration words
`define CMD_PHASE_POSITION    8'h37
`define CMD_SENSE_GAIN        8'h38
`define CMD_SENSE_OFFSET      8'h39
`define CMD_OV_FAULT_LIMIT    8'h40

// reset values
`define SENSE_GAIN_RESET      16'hAA66
`define SENSE_OFFSET_RESET    16'h0000

// linear-11 field positions
`define LIN11_EXP_MSB         4'hF
`define LIN11_EXP_LSB         4'hB
`define LIN11_MANT_MSB        4'hA

// limits, linear-11 values scaled by 2^16 (fraction bits)
`define LIN11_FRAC_BITS       6'h10
`define SENSE_GAIN_MAX        48'h0000_03E8_0000
`define SENSE_OFFSET_MAX      48'h0000_000A_0000
// 6.0 V at 2^-13 V per step
`define OV_LIMIT_MAX          16'hC000

// interleave field
`define PHASE_POS_MSB         2'h3
`define PHASE_STEP_DECIDEG    12'h0E1
`define PHASE_POS_ZERO_AS     5'h10

// fault threshold at reset is strap * 11 / 10
`define OV_STRAP_MUL          20'h0000B
`define OV_STRAP_DIV          20'h0000A

// cycles allowed for the pin synchronisers to settle after reset
`define STRAP_SETTLE_CYCLES   3'h5

`endif

// [logic/pwr_cfg_pkg.sv]
package pwr_cfg_pkg;

  // output state as seen by the overvoltage fault handling
  typedef enum logic [1:0] {
    OV_RUN,
    OV_WAIT_LOW,
    OV_LATCHED
  } ov_state_t;

  typedef logic signed [47:0] lin11_scaled_t;

endpackage

// [logic/pin_sync3.sv]
`timescale 1ns/100ps

// three-stage pin synchroniser; the output follows only when stages two and three agree
module pin_sync3 #(
  parameter int WIDTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinOut
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // stage1 feeds stage2 only, so metastability never reaches a compare
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // accept a change only once it has been stable for two samples
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pinOut <= '0;
    end else if (stage2 == stage3) begin
      pinOut <= stage3;
    end
  end

endmodule

// [logic/pwr_cfg_bank.sv]
`timescale 1ns/100ps
`include "pwr_cfg_params.svh"

module pwr_cfg_bank (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // command port, one access per cmdValid pulse
  input  wire logic        cmdValid,
  input  wire logic        cmdWrite,
  input  wire logic [7:0]  cmdCode,
  input  wire logic [15:0] cmdWdata,
  output logic             rspValid,
  output logic [15:0]      rspData,
  output logic             rspReject,
  // straps from pins
  input  wire logic [6:0]  pmbusAddr,
  input  wire logic [15:0] voltageSelectStrap,
  // same-clock monitor and fault controls
  input  wire logic [15:0] voutCode,
  input  wire logic [15:0] ovWarnCode,
  input  wire logic        retryEnable,
  input  wire logic        clearFaults,
  // outputs
  output logic [4:0]       phasePosition,
  output logic [11:0]      phaseOffsetDeciDeg,
  output logic [15:0]      senseGain,
  output logic [15:0]      senseOffset,
  output logic [15:0]      ovFaultLimit,
  output logic             statusWordVout,
  output logic             statusVoutOvFault,
  output logic             hostAlert,
  output logic             outputDisable,
  output logic             restartPulse
);

  logic [6:0]              addrSync;
  logic [15:0]             strapSync;
  logic [2:0]              settleCnt;
  logic                    strapLoad;
  logic [3:0]              positionField;
  logic [19:0]             strapProduct;
  logic                    wrStrobe;
  logic                    gainOk;
  logic                    offsetOk;
  logic                    ovOk;
  logic                    overVolt;
  pwr_cfg_pkg::ov_state_t  ovState;

  pin_sync3 #(.WIDTH(7)) u_addr_sync (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .pinIn   (pmbusAddr),
    .pinOut  (addrSync)
  );

  pin_sync3 #(.WIDTH(16)) u_strap_sync (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .pinIn   (voltageSelectStrap),
    .pinOut  (strapSync)
  );

  // decode linear-11
  // value scaled by 2^16 so negative exponents keep their fraction bits
  function automatic pwr_cfg_pkg::lin11_scaled_t lin11Scaled(input logic [15:0] word);
    logic signed [4:0]        expo;
    logic signed [10:0]       mant;
    logic signed [6:0]        shift;
    pwr_cfg_pkg::lin11_scaled_t wide;
    expo  = word[`LIN11_EXP_MSB:`LIN11_EXP_LSB];
    mant  = word[`LIN11_MANT_MSB:0];
    shift = 7'(expo) + 7'(`LIN11_FRAC_BITS);
    wide  = 48'(mant);
    lin11Scaled = wide <<< shift;
  endfunction

  assign gainOk = (lin11Scaled(cmdWdata) > 48'sh0000_0000_0000) &&
                  (lin11Scaled(cmdWdata) <= $signed(`SENSE_GAIN_MAX));
  assign offsetOk = (lin11Scaled(cmdWdata) <= $signed(`SENSE_OFFSET_MAX)) &&
                    (lin11Scaled(cmdWdata) >= -$signed(`SENSE_OFFSET_MAX));
  // unsigned 2^-13 V code, top 6.0 V
  assign ovOk = (cmdWdata <= `OV_LIMIT_MAX);

  assign wrStrobe = cmdValid && cmdWrite;
  assign strapProduct = (20'(strapSync) * `OV_STRAP_MUL) / `OV_STRAP_DIV;

  // hold straps back until the synchronisers have seen the pins for a while
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      settleCnt <= 3'h0;
      strapLoad <= 1'b0;
    end else begin
      strapLoad <= (settleCnt == `STRAP_SETTLE_CYCLES - 3'h1);
      if (settleCnt != `STRAP_SETTLE_CYCLES) begin
        settleCnt <= settleCnt + 3'h1;
      end
    end
  end

  // interleave position; only four bits exist, upper bits are never stored
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      positionField <= 4'h0;
    end else if (strapLoad) begin
      positionField <= addrSync[`PHASE_POS_MSB:0];
    end else if (wrStrobe && cmdCode == `CMD_PHASE_POSITION) begin
      positionField <= cmdWdata[`PHASE_POS_MSB:0];
    end
  end

  // position and phase; zero code stands for the last slot
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      phasePosition      <= 5'h00;
      phaseOffsetDeciDeg <= 12'h000;
    end else begin
      phasePosition <= (positionField == 4'h0) ? `PHASE_POS_ZERO_AS : {1'b0, positionField};
      // position times 22.5, sixteen gives 360
      phaseOffsetDeciDeg <= 12'(phasePosition * `PHASE_STEP_DECIDEG);
    end
  end

  // calibration words; an out-of-range write leaves the old value
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      senseGain   <= `SENSE_GAIN_RESET;
      senseOffset <= `SENSE_OFFSET_RESET;
    end else begin
      if (wrStrobe && cmdCode == `CMD_SENSE_GAIN && gainOk) begin
        senseGain <= cmdWdata;
      end
      if (wrStrobe && cmdCode == `CMD_SENSE_OFFSET && offsetOk) begin
        senseOffset <= cmdWdata;
      end
    end
  end

  // overvoltage fault limit, reloaded from the strap after reset
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ovFaultLimit <= 16'h0000;
    end else if (strapLoad) begin
      // strap derived default, saturated to the field
      ovFaultLimit <= (strapProduct[19:16] != 4'h0) ? 16'hFFFF : strapProduct[15:0];
    end else if (wrStrobe && cmdCode == `CMD_OV_FAULT_LIMIT && ovOk) begin
      ovFaultLimit <= cmdWdata;
    end
  end

  // answer one cycle after the command; unknown codes and bad writes are refused
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rspValid  <= 1'b0;
      rspData   <= 16'h0000;
      rspReject <= 1'b0;
    end else begin
      rspValid  <= cmdValid;
      rspReject <= 1'b0;
      rspData   <= 16'h0000;
      if (cmdValid) begin
        unique case (cmdCode)
          `CMD_PHASE_POSITION: begin
            rspData <= {12'h000, positionField};
          end
          `CMD_SENSE_GAIN: begin
            rspData   <= senseGain;
            rspReject <= cmdWrite && !gainOk;
          end
          `CMD_SENSE_OFFSET: begin
            rspData   <= senseOffset;
            rspReject <= cmdWrite && !offsetOk;
          end
          `CMD_OV_FAULT_LIMIT: begin
            rspData   <= ovFaultLimit;
            rspReject <= cmdWrite && !ovOk;
          end
          default: rspReject <= 1'b1;  // not a command of this bank
        endcase
      end
    end
  end

  assign overVolt = (voutCode > ovFaultLimit);

  // sticky status and alert; a new fault beats clearFaults
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      statusWordVout    <= 1'b0;
      statusVoutOvFault <= 1'b0;
      hostAlert         <= 1'b0;
    end else if (overVolt && ovState == pwr_cfg_pkg::OV_RUN) begin
      statusWordVout    <= 1'b1;
      statusVoutOvFault <= 1'b1;
      hostAlert         <= 1'b1;
    end else if (clearFaults) begin
      statusWordVout    <= 1'b0;
      statusVoutOvFault <= 1'b0;
      hostAlert         <= 1'b0;
    end
  end

  // fault response: shut down, then either latch or wait for the voltage to fall
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ovState       <= pwr_cfg_pkg::OV_RUN;
      outputDisable <= 1'b0;
      restartPulse  <= 1'b0;
    end else begin
      restartPulse <= 1'b0;
      unique case (ovState)
        pwr_cfg_pkg::OV_RUN: begin
          if (overVolt) begin
            outputDisable <= 1'b1;
            ovState       <= retryEnable ? pwr_cfg_pkg::OV_WAIT_LOW : pwr_cfg_pkg::OV_LATCHED;
          end
        end
        pwr_cfg_pkg::OV_WAIT_LOW: begin
          // no restart above the warning threshold
          // a warning threshold above the fault limit could restart into a fault
          if (voutCode < ovWarnCode) begin
            outputDisable <= 1'b0;
            restartPulse  <= 1'b1;
            ovState       <= pwr_cfg_pkg::OV_RUN;
          end
        end
        pwr_cfg_pkg::OV_LATCHED: begin
          outputDisable <= 1'b1;  // only a reset brings the output back
        end
      endcase
    end
  end

endmodule

// [verification/pwr_cfg_bank_monitor.sv]
`timescale 1ns/100ps
// watches the bank's ports only
module pwr_cfg_bank_monitor (
  input logic        sys_clk,
  input logic        sys_rst,
  input logic        cmdValid,
  input logic        cmdWrite,
  input logic [7:0]  cmdCode,
  input logic [15:0] cmdWdata,
  input logic        rspValid,
  input logic        rspReject,
  input logic [15:0] voutCode,
  input logic [15:0] ovWarnCode,
  input logic        clearFaults,
  input logic [4:0]  phasePosition,
  input logic [11:0] phaseOffsetDeciDeg,
  input logic [15:0] senseGain,
  input logic [15:0] ovFaultLimit,
  input logic        statusWordVout,
  input logic        statusVoutOvFault,
  input logic        hostAlert,
  input logic        outputDisable,
  input logic        restartPulse
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_rsp_follows: assert property (cmdValid |=> rspValid)
    else $error("no answer");
  a_gain_reset: assert property ($past(sys_rst) |-> senseGain == 16'hAA66)
    else $error("gain reset wrong");
  // the field lands one edge after the write, the decoded position one edge later
  a_pos_write: assert property (cmdValid && cmdWrite && cmdCode == 8'h37 |-> ##2
    phasePosition == ($past(cmdWdata[3:0], 2) == 4'h0 ? 5'h10 : {1'b0, $past(cmdWdata[3:0], 2)}))
    else $error("position wrong");
  a_offset_scale: assert property (phaseOffsetDeciDeg == $past(phasePosition) * 12'h0E1)
    else $error("offset wrong");
  a_ov_reject: assert property (cmdValid && cmdWrite && cmdCode == 8'h40
    && cmdWdata > 16'hC000 |=> rspReject && $stable(ovFaultLimit))
    else $error("limit accepted");
  a_ov_detect: assert property (voutCode > ovFaultLimit && !outputDisable |=>
    statusWordVout && statusVoutOvFault && hostAlert && outputDisable)
    else $error("fault missed");
  a_status_hold: assert property (statusVoutOvFault && !clearFaults |=> statusVoutOvFault)
    else $error("status lost");
  a_retry_gate: assert property ($rose(restartPulse) |->
    $past(voutCode) < $past(ovWarnCode) && $past(outputDisable))
    else $error("early restart");
  a_pulse_once: assert property (restartPulse |-> !outputDisable ##1 !restartPulse)
    else $error("restart pulse wrong");
endmodule

bind pwr_cfg_bank pwr_cfg_bank_monitor mon (.sys_clk, .sys_rst, .cmdValid, .cmdWrite,
  .cmdCode, .cmdWdata, .rspValid, .rspReject, .voutCode, .ovWarnCode, .clearFaults,
  .phasePosition, .phaseOffsetDeciDeg, .senseGain, .ovFaultLimit, .statusWordVout,
  .statusVoutOvFault, .hostAlert, .outputDisable, .restartPulse);

// [verification/pmbus_host_model.sv]
`timescale 1ns/100ps
// host side of the command port
module pmbus_host_model (
  input  logic        sys_clk,
  output logic        cmdValid,
  output logic        cmdWrite,
  output logic [7:0]  cmdCode,
  output logic [15:0] cmdWdata,
  output logic [15:0] ovWarnCode
);
  // idle bus at time zero
  initial begin
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdCode = 8'h00;
    cmdWdata = 16'h0000;
    ovWarnCode = 16'hFFFF;
  end

  // one access; data inverted after so nothing stale is seen
  task automatic acc(input logic w, input logic [7:0] c, input logic [15:0] d);
    @(posedge sys_clk);
    cmdValid <= 1'b1;
    cmdWrite <= w;
    cmdCode <= c;
    cmdWdata <= d;
    @(posedge sys_clk);
    cmdValid <= 1'b0;
    cmdWdata <= ~d;
  endtask

  task automatic warn(input logic [15:0] lim);
    @(posedge sys_clk);
    ovWarnCode <= lim - 16'h0333;
  endtask
endmodule

// [verification/tb_top.sv]
`timescale 1ns/100ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module tb_top;
  logic        sys_clk, sys_rst, cmdValid, cmdWrite, rspValid, rspReject, retryEnable;
  logic        clearFaults, statusWordVout, statusVoutOvFault, hostAlert, outputDisable;
  logic        restartPulse;
  logic [7:0]  cmdCode;
  logic [6:0]  pmbusAddr;
  logic [4:0]  phasePosition;
  logic [11:0] phaseOffsetDeciDeg;
  logic [15:0] cmdWdata, rspData, voltageSelectStrap, voutCode, ovWarnCode, senseGain;
  logic [15:0] senseOffset, ovFaultLimit, d, ovVal, pos, cur [2];
  logic [17:0] q, expQ [$];
  logic [17:0] tab [13] = '{18'h1_0000, 18'h0_03E8, 18'h1_03E9, 18'h0_09F4, 18'h1_09F5,
    18'h1_07FF, 18'h0_F801, 18'h2_000A, 18'h3_000B, 18'h2_07F6, 18'h3_07F5, 18'h3_1003,
    18'h2_0802};
  int          err_count, check_count, cyc, k;

  pwr_cfg_bank uut (.sys_clk, .sys_rst, .cmdValid, .cmdWrite, .cmdCode, .cmdWdata,
    .rspValid, .rspData, .rspReject, .pmbusAddr, .voltageSelectStrap, .voutCode,
    .ovWarnCode, .retryEnable, .clearFaults, .phasePosition, .phaseOffsetDeciDeg,
    .senseGain, .senseOffset, .ovFaultLimit, .statusWordVout, .statusVoutOvFault,
    .hostAlert, .outputDisable, .restartPulse);
  pmbus_host_model host (.sys_clk, .cmdValid, .cmdWrite, .cmdCode, .cmdWdata, .ovWarnCode);

  // 125 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // note the answer before the strobe; e is {check data, reject, data}
  task automatic rw(input logic w, input logic [7:0] c, input logic [15:0] v,
                    input logic [17:0] e);
    expQ.push_back(e);
    host.acc(w, c, v);
  endtask

  // answers compared with the oldest note
  always @(posedge sys_clk) begin
    if (rspValid === 1'b1) begin
      q = expQ.size() > 0 ? expQ.pop_front() : 18'h3_FFFF;
      `CHK("reject", q[16], rspReject)
      if (q[17]) `CHK("data", q[15:0], rspData)
    end
  end

  // cuts a hang short
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      end_sim();
    end
  end

  initial begin
    void'($urandom(32'h70aabca8));
    {sys_rst, retryEnable, clearFaults, voutCode} = {3'b110, 16'h0000};
    pmbusAddr = 7'h5A;
    voltageSelectStrap = 16'h2000;
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (10) @(posedge sys_clk);
    `CHK("limit", 16'h2333, ovFaultLimit)
    `CHK("position", 5'h0A, phasePosition)
    rw(0, 8'h37, 16'h0000, 18'h2_000A);
    rw(0, 8'h39, 16'h0000, 18'h2_0000);
    rw(0, 8'h41, 16'h0000, 18'h1_0000);
    rw(1, 8'h36, 16'h1234, 18'h1_0000);
    // range edges of both calibration words
    {cur[0], cur[1]} = {16'hAA66, 16'h0000};
    foreach (tab[i]) begin
      k = int'(tab[i][17]);
      rw(1, {7'h1C, tab[i][17]}, tab[i][15:0], {1'b1, tab[i][16], cur[k]});
      if (!tab[i][16]) cur[k] = tab[i][15:0];
    end
    @(posedge sys_clk);
    `CHK("gain", cur[0], senseGain)
    `CHK("offset", cur[1], senseOffset)
    ovVal = 16'h2333;
    repeat (24) begin
      d = ($urandom & 1) ? 16'($urandom) : 16'hBFF8 + 16'($urandom_range(15, 0));
      rw(1, 8'h40, d, {1'b1, d > 16'hC000, ovVal});
      if (d <= 16'hC000) ovVal = d;
    end
    rw(1, 8'h40, 16'h2333, {2'b10, ovVal});
    pos = 16'h000A;
    for (k = 0; k < 18; k++) begin
      d = k == 16 ? 16'hFFF1 : k == 17 ? 16'h0000 : 16'($urandom);
      rw(1, 8'h37, d, {2'b10, pos});
      pos = {12'h000, d[3:0]};
      // offset trails the position by one edge, so look once it has settled
      if (k == 16) begin
        repeat (2) @(posedge sys_clk);
        #1 `CHK("offset one", 12'h0E1, phaseOffsetDeciDeg)
      end
    end
    repeat (2) @(posedge sys_clk);
    `CHK("pos zero", 5'h10, phasePosition)
    rw(0, 8'h37, 16'h0000, 18'h2_0000);
    host.warn(16'h2333);
    voutCode <= 16'h3000;
    @(posedge sys_clk);
    voutCode <= 16'h2100;
    repeat (6) @(posedge sys_clk);
    `CHK("fault", 5'h1E, {statusWordVout, statusVoutOvFault, hostAlert, outputDisable, restartPulse})
    voutCode <= 16'h1000;
    // restart pulse stands for the one cycle after the low voltage is seen
    @(posedge sys_clk);
    #1 `CHK("restart", 2'b01, {outputDisable, restartPulse})
    @(posedge sys_clk);
    clearFaults <= 1'b1;
    @(posedge sys_clk);
    clearFaults <= 1'b0;
    @(posedge sys_clk);
    #1 `CHK("cleared", 3'b000, {statusWordVout, statusVoutOvFault, hostAlert})
    @(posedge sys_clk);
    {retryEnable, voutCode} <= {1'b0, 16'h3000};
    @(posedge sys_clk);
    voutCode <= 16'h1000;
    repeat (6) @(posedge sys_clk);
    #1 `CHK("latched", 2'b10, {outputDisable, restartPulse})
    end_sim();
  end
endmodule
